// File: inc/svd_defines.vh
`ifndef SVD_DEFINES_VH
`define SVD_DEFINES_VH

// register indices; byte address is four times the index
`define SVD_IDX_CTRL 14'h0F2A
`define SVD_IDX_LEVEL 14'h0F2B
`define SVD_IDX_STATUS 14'h0F2C
`define SVD_IDX_MASK 14'h0F2D
`define SVD_IDX_SETTLE 14'h0F2E

// control register fields
`define SVD_CTRL_EN 7
`define SVD_CTRL_OUT 5
`define SVD_CTRL_RDY 4
`define SVD_CTRL_HI 1
`define SVD_CTRL_LO 0

// level register field
`define SVD_LEVEL_MSB 3
`define SVD_LEVEL_RSVD 4'hF

// status and mask fields
`define SVD_ST_EVENT 0
`define SVD_ST_READY 1
`define SVD_ST_W 2

// reset values
`define SVD_CTRL_RST 8'h00
`define SVD_EN_RST 1'b0
`define SVD_LEVEL_RST 4'h0
`define SVD_STATUS_RST 2'h0
`define SVD_MASK_RST 2'h0

// timing
`define SVD_CLK_MHZ 100
`define SVD_SETTLE_NS 10000
`define SVD_CNT_W 16

`endif

// File: rtl/svd_ctrl.v
`timescale 1ns/10ps
// Summary of operation
// - detector powered and active only while control bit 7 is one
// - no event flag until the reference settle interval has elapsed after enable
// - settle interval is a time in ns, converted by the clock rate
// - control bit 4 reads one when reference stable and output valid
// - control bit 5 reads one when supply at or below selected limit
// - high-trip enable bit 1 sets event flag when supply above limit
// - low-trip enable bit 0 sets event flag when supply at or below limit
// - clearing flag while condition persists leaves it set
// - in sleep detector keeps running; event flag raises a wake request
// - idle and doze change nothing; detector stays fully active
// - any reset returns registers other than trip level to reset values, detector off
// - 4-bit trip level field, codes 0000 to 1110, 1111 reserved
// - trip level resets to 0000 only on power-on or brown-out reset
// - interrupt only when a status bit (event or ready), its mask bit and global irq enable are set
`include "svd_defines.vh"

module svd_ctrl #(
   parameter integer P_SETTLE_NS = `SVD_SETTLE_NS
) (
   input wire i_mclk, // system clock, 100 MHz
   input wire i_srst, // synchronous reset, any device reset
   input wire i_por_bor, // high with i_srst for power-on or brown-out
   input wire [15:0] i_avs_address, // byte address
   input wire i_avs_read, // read request
   input wire i_avs_write, // write request
   input wire [31:0] i_avs_writedata, // write data
   input wire [3:0] i_avs_byteenable, // byte lanes
   output reg [31:0] o_avs_readdata, // read data
   output wire o_avs_waitrequest, // stall
   input wire i_cmp_low, // analog comparator, 1 = supply at or below limit
   input wire i_ref_stable, // band-gap reference stable
   input wire i_sleep, // device in sleep
   input wire i_idle_doze, // device in idle or doze
   input wire i_global_irq_en, // global interrupt enable
   output reg o_det_enable, // powers comparator and divider
   output reg [3:0] o_level_sel, // trip level to the divider
   output reg o_wake_req, // wake from sleep
   output reg o_irq // level interrupt
);

   localparam integer SETTLE_CYC_RAW = (P_SETTLE_NS * `SVD_CLK_MHZ + 999) / 1000;
   localparam integer SETTLE_CYC_I = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
   localparam [`SVD_CNT_W-1:0] SETTLE_CYC = SETTLE_CYC_I[`SVD_CNT_W-1:0];

   // one-hot register selects
   localparam [4:0] SEL_NONE = 5'h00;
   localparam [4:0] SEL_CTRL = 5'h01;
   localparam [4:0] SEL_LEVEL = 5'h02;
   localparam [4:0] SEL_STATUS = 5'h04;
   localparam [4:0] SEL_MASK = 5'h08;
   localparam [4:0] SEL_SETTLE = 5'h10;

   function [4:0] svd_decode;
      input [15:0] addr;
      begin
         case (addr[15:2])
            `SVD_IDX_CTRL: svd_decode = SEL_CTRL;
            `SVD_IDX_LEVEL: svd_decode = SEL_LEVEL;
            `SVD_IDX_STATUS: svd_decode = SEL_STATUS;
            `SVD_IDX_MASK: svd_decode = SEL_MASK;
            `SVD_IDX_SETTLE: svd_decode = SEL_SETTLE;
            default: svd_decode = SEL_NONE;
         endcase
      end
   endfunction

   // ---------------- pin synchronisers ----------------
   // three stages plus agree filter; a pin flipping every clock is held off
   wire [1:0] pin_in;
   wire [1:0] pin_f;
   assign pin_in = {i_ref_stable, i_cmp_low};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         reg s1_q;
         reg s2_q;
         reg s3_q;
         reg f_q;
         always @(posedge i_mclk) begin
            if (i_srst) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               f_q <= 1'b0;
            end else begin
               s1_q <= pin_in[gi];
               s2_q <= s1_q;
               s3_q <= s2_q;
               // change taken only once two stages agree
               if (s2_q == s3_q) begin
                  f_q <= s3_q;
               end
            end
         end
         assign pin_f[gi] = f_q;
      end
   endgenerate

   wire cmp_low_f;
   wire ref_stable_f;
   assign cmp_low_f = pin_f[0];
   assign ref_stable_f = pin_f[1];

   // ---------------- bus slave ----------------
   reg ack_q;
   wire access;
   wire [4:0] sel;
   wire wr_ok;
   wire wr_lane0;
   assign access = i_avs_read | i_avs_write;
   assign sel = svd_decode(i_avs_address);
   assign o_avs_waitrequest = access & ~ack_q;
   // writes land at the edge where waitrequest is low
   assign wr_lane0 = i_avs_write & ack_q & i_avs_byteenable[0];
   assign wr_ok = wr_lane0;

   always @(posedge i_mclk) begin
      if (i_srst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access & ~ack_q;
      end
   end

   // ---------------- registers ----------------
   reg en_q;
   reg hi_en_q;
   reg lo_en_q;
   reg [3:0] level_q;
   reg [`SVD_ST_W-1:0] status_q;
   reg [`SVD_ST_W-1:0] mask_q;
   reg [`SVD_CNT_W-1:0] cnt_q;
   reg ready_q;

   wire [7:0] wbyte;
   assign wbyte = i_avs_writedata[7:0];

   always @(posedge i_mclk) begin
      if (i_srst) begin
         en_q <= `SVD_EN_RST;
         hi_en_q <= 1'b0;
         lo_en_q <= 1'b0;
      end else if (wr_ok && sel == SEL_CTRL) begin
         en_q <= wbyte[`SVD_CTRL_EN];
         hi_en_q <= wbyte[`SVD_CTRL_HI];
         lo_en_q <= wbyte[`SVD_CTRL_LO];
      end
   end

   // level survives resets other than power-on and brown-out
   always @(posedge i_mclk) begin
      if (i_srst) begin
         if (i_por_bor) begin
            level_q <= `SVD_LEVEL_RST;
         end
      end else if (wr_ok && sel == SEL_LEVEL) begin
         // reserved code is not accepted
         if (wbyte[`SVD_LEVEL_MSB:0] != `SVD_LEVEL_RSVD) begin
            level_q <= wbyte[`SVD_LEVEL_MSB:0];
         end
      end
   end

   always @(posedge i_mclk) begin
      if (i_srst) begin
         mask_q <= `SVD_MASK_RST;
      end else if (wr_ok && sel == SEL_MASK) begin
         mask_q <= wbyte[`SVD_ST_W-1:0];
      end
   end

   // ---------------- settle timer ----------------
   // counts from each enable; restarts whenever the detector is turned off
   // limitation: clock rate is a build constant, another clock needs a rebuild
   wire settled;
   assign settled = (cnt_q == SETTLE_CYC);

   always @(posedge i_mclk) begin
      if (i_srst) begin
         cnt_q <= {`SVD_CNT_W{1'b0}};
      end else if (!en_q) begin
         cnt_q <= {`SVD_CNT_W{1'b0}};
      end else if (!settled) begin
         cnt_q <= cnt_q + {{(`SVD_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // ready needs both the elapsed time and the reference's own indication
   wire ready_d;
   assign ready_d = en_q & settled & ref_stable_f;

   always @(posedge i_mclk) begin
      if (i_srst) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= ready_d;
      end
   end

   // ---------------- event detection ----------------
   // power mode inputs deliberately not used: idle and doze keep events running
   // comparator seen through the filter, so trips lag the pin by about four clocks
   wire trip_hi;
   wire trip_lo;
   wire trip;
   assign trip_hi = hi_en_q & ~cmp_low_f;
   assign trip_lo = lo_en_q & cmp_low_f;
   assign trip = en_q & ready_q & (trip_hi | trip_lo);

   wire ready_rise;
   reg ready_prev_q;
   assign ready_rise = ready_q & ~ready_prev_q;

   always @(posedge i_mclk) begin
      if (i_srst) begin
         ready_prev_q <= 1'b0;
      end else begin
         ready_prev_q <= ready_q;
      end
   end

   // ready-rise bit lets software poll one register instead of control
   wire [`SVD_ST_W-1:0] st_set;
   wire [`SVD_ST_W-1:0] st_clr;
   assign st_set = {ready_rise, trip};
   assign st_clr = (wr_ok && sel == SEL_STATUS) ? wbyte[`SVD_ST_W-1:0] :
                   {`SVD_ST_W{1'b0}};

   always @(posedge i_mclk) begin
      if (i_srst) begin
         status_q <= `SVD_STATUS_RST;
      end else begin
         // set wins over a clear in the same cycle
         status_q <= (status_q & ~st_clr) | st_set;
      end
   end

   // ---------------- outputs ----------------
   always @(posedge i_mclk) begin
      if (i_srst) begin
         o_det_enable <= 1'b0;
         o_level_sel <= `SVD_LEVEL_RST;
         o_wake_req <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         o_det_enable <= en_q;
         o_level_sel <= level_q;
         // wake needs no global enable; only vectoring depends on it
         o_wake_req <= i_sleep & en_q & status_q[`SVD_ST_EVENT];
         // mask and global enable only gate the line; the flag itself is kept
         o_irq <= i_global_irq_en & |(status_q & mask_q);
      end
   end

   // ---------------- read mux ----------------
   // unmapped reads return zero rather than stalling the bus
   reg [7:0] rbyte;
   always @* begin
      rbyte = 8'h00;
      case (sel)
         SEL_CTRL: begin
            rbyte[`SVD_CTRL_EN] = en_q;
            rbyte[`SVD_CTRL_OUT] = en_q & cmp_low_f;
            rbyte[`SVD_CTRL_RDY] = ready_q;
            rbyte[`SVD_CTRL_HI] = hi_en_q;
            rbyte[`SVD_CTRL_LO] = lo_en_q;
         end
         SEL_LEVEL: begin
            rbyte[`SVD_LEVEL_MSB:0] = level_q;
         end
         SEL_STATUS: begin
            rbyte[`SVD_ST_W-1:0] = status_q;
         end
         SEL_MASK: begin
            rbyte[`SVD_ST_W-1:0] = mask_q;
         end
         SEL_SETTLE: begin
            // saturating view; full count only matters as progress
            rbyte = (cnt_q > 16'h00FF) ? 8'hFF : cnt_q[7:0];
         end
         default: begin
            rbyte = 8'h00;
         end
      endcase
   end

   // data captured in the wait cycle, held through the completing edge
   always @(posedge i_mclk) begin
      if (i_srst) begin
         o_avs_readdata <= 32'h00000000;
      end else if (i_avs_read && !ack_q) begin
         o_avs_readdata <= {24'h000000, rbyte};
      end
   end

   // idle/doze indication kept only for the record of power state
   wire unused_mode;
   assign unused_mode = i_idle_doze;

endmodule

// File: rtl/svd_placeholder_none.v
`timescale 1ns/10ps

// File: tb/supply_voltage_detect_ctrl_tb_top.sv
`timescale 1ns/10ps
`include "svd_defines.vh"
module supply_voltage_detect_ctrl_tb_top;
   localparam logic [15:0] A_CTRL = {`SVD_IDX_CTRL, 2'b00};
   localparam logic [15:0] A_LVL = {`SVD_IDX_LEVEL, 2'b00};
   localparam logic [15:0] A_ST = {`SVD_IDX_STATUS, 2'b00};
   localparam logic [15:0] A_MASK = {`SVD_IDX_MASK, 2'b00};
   // address, write data, expected read-back
   localparam logic [31:0] ROWS [8] = '{{A_CTRL, 8'h03, 8'h03}, {A_LVL, 8'h0E, 8'h0E},
      {A_LVL, 8'h0F, 8'h0E}, {A_LVL, 8'hF5, 8'h05}, {A_MASK, 8'h03, 8'h03},
      {16'h3CC0, 8'h5A, 8'h00}, {{`SVD_IDX_SETTLE, 2'b00}, 8'hFF, 8'h00}, {A_LVL, 8'h03, 8'h03}};
   logic clk = 0, srst = 1, por = 1, rd = 0, wr = 0, below = 1, slow = 1;
   logic sleep = 0, idle = 0, global_irq_enable = 0, wreq, cmp, refs, den, wake, irq;
   logic [15:0] adr = 16'h0;
   logic [31:0] wd = 32'h0, rdata, r;
   logic [3:0] lsel;
   integer failures = 0, check_count = 0, cyc = 0, i;
   svd_ctrl #(.P_SETTLE_NS(50)) svd_ctrl_i (.i_mclk(clk), .i_srst(srst), .i_por_bor(por),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
      .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
      .i_cmp_low(cmp), .i_ref_stable(refs), .i_sleep(sleep), .i_idle_doze(idle),
      .i_global_irq_en(global_irq_enable), .o_det_enable(den), .o_level_sel(lsel), .o_wake_req(wake),
      .o_irq(irq));
   svd_analog svd_analog_i (.i_clk(clk), .i_power(den), .i_below(below), .i_slow(slow),
      .o_cmp_low(cmp), .o_ref_stable(refs));
   initial begin
      forever #5 clk = ~clk;
   end
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", check_count, failures);
         if (failures == 0 && check_count > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         print_verdict;
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      begin
         check_count++;
         if (g !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   // read right after the edge, waitrequest and data are what that edge sampled
   task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
      begin
         @(posedge clk);
         rd <= !w;
         wr <= w;
         adr <= a;
         wd <= {24'h0, d};
         do @(posedge clk); while (wreq !== 1'b0);
         r = rdata;
         rd <= 0;
         wr <= 0;
      end
   endtask
   task wait_rdy;
      do bus(0, A_CTRL, 8'h00); while (r[4] !== 1'b1);
   endtask
   task rst(input logic pb);
      begin
         @(posedge clk);
         srst <= 1;
         por <= pb;
         repeat (10) @(posedge clk);
         srst <= 0;
         por <= 0;
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      srst <= 0;
      por <= 0;
      for (i = 0; i < 8; i++) begin
         bus(1, ROWS[i][31:16], ROWS[i][15:8]);
         bus(0, ROWS[i][31:16], 8'h00);
         chk(r, {24'h0, ROWS[i][7:0]});
      end
      bus(1, A_CTRL, 8'h81);
      bus(0, A_ST, 8'h00);
      chk(r, 32'h0);
      wait_rdy;
      chk(r, 32'hB1);
      bus(0, {`SVD_IDX_SETTLE, 2'b00}, 8'h00);
      chk(r, 32'h5);
      bus(0, A_ST, 8'h00);
      chk(r, 32'h3);
      bus(1, A_ST, 8'h03);
      bus(0, A_ST, 8'h00);
      chk(r, 32'h1);
      global_irq_enable <= 1;
      repeat (3) @(posedge clk);
      chk(irq, 32'h1);
      global_irq_enable <= 0;
      bus(1, A_CTRL, 8'h00);
      bus(1, A_ST, 8'h03);
      slow <= 0;
      sleep <= 1;
      idle <= 1;
      bus(1, A_CTRL, 8'h82);
      wait_rdy;
      bus(0, A_ST, 8'h00);
      chk(r, 32'h2);
      chk(wake, 32'h0);
      below <= 0;
      repeat (12) @(posedge clk);
      bus(0, A_ST, 8'h00);
      chk(r, 32'h3);
      chk(wake, 32'h1);
      rst(0);
      bus(0, A_LVL, 8'h00);
      chk(r, 32'h3);
      bus(0, A_CTRL, 8'h00);
      chk(r, 32'h0);
      rst(1);
      bus(0, A_LVL, 8'h00);
      chk(r, 32'h0);
      print_verdict;
   end
endmodule

// File: tb/svd_analog.sv
`timescale 1ns/10ps
module svd_analog (
   input wire i_clk, // clock
   input wire i_power, // detector powered
   input wire i_below, // supply at or below limit
   input wire i_slow, // slow reference start
   output reg o_cmp_low = 1'b0, // comparator
   output reg o_ref_stable = 1'b0 // reference stable
);
   integer cnt = 0;
   always @(posedge i_clk) begin
      cnt <= i_power ? cnt + 1 : 0;
      o_ref_stable <= i_power && cnt >= (i_slow ? 40 : 2);
      // unpowered comparator output means nothing, so it toggles
      o_cmp_low <= i_power ? i_below : ~o_cmp_low;
   end
endmodule

// File: tb/svd_ctrl_chk.sv
`timescale 1ns/10ps
`include "svd_defines.vh"
module svd_ctrl_chk #(
   parameter integer P_SETTLE_NS = 50
) (
   input wire i_mclk, // clock
   input wire i_srst, // reset
   input wire [15:0] i_avs_address, // address
   input wire i_avs_read, // read
   input wire i_avs_write, // write
   input wire [31:0] i_avs_writedata, // data
   input wire [3:0] i_avs_byteenable, // lanes
   input wire [31:0] o_avs_readdata, // read data
   input wire o_avs_waitrequest, // stall
   input wire i_sleep, // sleep
   input wire i_global_irq_en, // global enable
   input wire o_det_enable, // detector on
   input wire [3:0] o_level_sel, // trip level
   input wire o_wake_req, // wake
   input wire o_irq // interrupt
);
   wire wr_done = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
   wire wr_ctrl = wr_done && i_avs_address[15:2] == `SVD_IDX_CTRL;
   wire wr_lvl = wr_done && i_avs_address[15:2] == `SVD_IDX_LEVEL;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   sequence s_one_wait;
      o_avs_waitrequest ##1 !o_avs_waitrequest;
   endsequence
   // settle of 5 cycles at the bench's 50 ns setting
   sequence s_quiet;
      !o_wake_req [*5];
   endsequence
   wait_state_a: assert property ($rose(i_avs_read || i_avs_write) |-> s_one_wait)
      else $error("bus answer not after one wait state");
   det_enable_a: assert property (wr_ctrl |-> ##2 o_det_enable == $past(i_avs_writedata[7], 2))
      else $error("detector enable does not follow control bit 7");
   level_load_a: assert property (wr_lvl && i_avs_writedata[3:0] != 4'hF
      |-> ##2 o_level_sel == $past(i_avs_writedata[3:0], 2))
      else $error("trip level not loaded");
   level_rsvd_a: assert property (wr_lvl && i_avs_writedata[3:0] == 4'hF |-> ##2 $stable(o_level_sel))
      else $error("reserved trip level accepted");
   irq_gate_a: assert property (o_irq |-> $past(i_global_irq_en))
      else $error("interrupt without global enable");
   wake_gate_a: assert property (o_wake_req |-> o_det_enable && $past(i_sleep))
      else $error("wake request outside enabled sleep");
   settle_quiet_a: assert property ($rose(o_det_enable) |-> s_quiet)
      else $error("event before reference settled");
   reset_clear_a: assert property ($fell(i_srst)
      |-> !o_det_enable && !o_irq && !o_wake_req && o_avs_readdata == 32'h0)
      else $error("outputs not cleared by reset");
endmodule
bind svd_ctrl svd_ctrl_chk #(.P_SETTLE_NS(P_SETTLE_NS)) svd_ctrl_chk_i (.*);
